// *** design/host_uart_tx_double_buffer.sv ***
// host transmit holding register and mpu shift buffer with delay pacing
// ------------------------------------------------------------
// ------------------------------------------------------------
module host_uart_tx_double_buffer
  import tx_dbuf_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host side write port, same clock domain
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  // host status bits
  output logic holding_empty_flag,
  output logic transmitter_empty_flag,
  // mpu requests
  output logic mpu_interrupt_request,
  output logic dma_request,
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] host_tx_holding_reg_r, host_tx_holding_reg_nxt;
  logic hold_full_r, hold_full_nxt;
  logic hold_empty_r, hold_empty_nxt;
  logic [7:0] mpu_tx_shift_buffer_r, mpu_tx_shift_buffer_nxt;
  logic shift_full_r, shift_full_nxt;
  logic [DELAY_W-1:0] timer_r, timer_nxt;
  logic timed_out_r, timed_out_nxt;
  logic read_seen_r, read_seen_nxt;
  logic host_empty_r, host_empty_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [DELAY_W-1:0] delay_r, delay_nxt;
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic req_r, req_nxt;

  // pready is registered: it rises one cycle into the access phase, and
  // writes and the emptying read land only at the edge that completes it
  logic acc, done, wr_done, rd_acc, fifo_reset, move, mpu_read;
  logic host_empty_set, delay_mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction
  // writable offsets; any other write is answered with an error
  function automatic logic wr_mapped(input logic [7:0] a);
    wr_mapped = hit(a, ADDR_CTRL) || hit(a, ADDR_IRQ_CLR)
      || hit(a, ADDR_IRQ_EN) || hit(a, ADDR_DELAY);
  endfunction

  assign acc = apb_req.psel && apb_req.penable && !pready_r;
  assign done = apb_req.psel && apb_req.penable && pready_r;
  assign wr_done = done && apb_req.pwrite;
  assign rd_acc = acc && !apb_req.pwrite;
  assign delay_mode = ctrl_r[CTRL_CHAR_DELAY];
  assign fifo_reset = wr_done && hit(apb_req.paddr, ADDR_CTRL)
    && apb_req.pwdata[CTRL_FIFO_RESET];
  // reading the shift buffer empties it once the transfer completes
  assign mpu_read = done && !apb_req.pwrite
    && hit(apb_req.paddr, ADDR_SHIFT);

  // ------------------------------------------------------------
  // transfer and flags
  // ------------------------------------------------------------
  // move holding to shift; with delay mode it waits for time-out
  always_comb
  begin
    move = ctrl_r[CTRL_ENABLE] && hold_full_r && !shift_full_r
      && (!delay_mode || timed_out_r);
    // in delay mode host empty set needs read, empty holding and shift, and expired timer
    if (delay_mode)
      host_empty_set = read_seen_r && !hold_full_r && !shift_full_r
        && timer_r == DELAY_ZERO && !move;
    else
      host_empty_set = !hold_full_r && !shift_full_r && !move;
  end

  // next state of the data path
  always_comb
  begin
    host_tx_holding_reg_nxt = host_tx_holding_reg_r;
    hold_full_nxt = hold_full_r;
    mpu_tx_shift_buffer_nxt = mpu_tx_shift_buffer_r;
    shift_full_nxt = shift_full_r;
    timer_nxt = timer_r;
    timed_out_nxt = timed_out_r;
    read_seen_nxt = read_seen_r;
    host_empty_nxt = host_empty_r;
    if (timer_r != DELAY_ZERO)
      timer_nxt = timer_r - DELAY_ONE;
    if (move)
    begin
      mpu_tx_shift_buffer_nxt = host_tx_holding_reg_r;
      shift_full_nxt = 1'b1;
      hold_full_nxt = 1'b0;
      timer_nxt = delay_r;
      timed_out_nxt = 1'b0;
      read_seen_nxt = 1'b0;
    end
    else if (timer_r == DELAY_ONE)
      timed_out_nxt = 1'b1;
    if (mpu_read && shift_full_r)
    begin
      shift_full_nxt = 1'b0;
      read_seen_nxt = 1'b1;
    end
    // a fresh host byte lands whenever the holding register frees
    if (host_wr && (!hold_full_r || move))
    begin
      host_tx_holding_reg_nxt = host_wdata;
      hold_full_nxt = 1'b1;
    end
    if (host_empty_set && !host_wr)
    begin
      host_empty_nxt = 1'b1;
      timed_out_nxt = 1'b1;
    end
    else if (host_wr || hold_full_r || shift_full_r)
      host_empty_nxt = 1'b0;
    if (fifo_reset)
    begin
      hold_full_nxt = 1'b0;
      shift_full_nxt = 1'b0;
      timer_nxt = DELAY_ZERO;
      timed_out_nxt = 1'b1;
      read_seen_nxt = 1'b1;
      host_empty_nxt = 1'b1;
    end
    hold_empty_nxt = !hold_full_nxt;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      host_tx_holding_reg_r <= 8'h00;
      hold_full_r <= 1'b0;
      hold_empty_r <= 1'b1;
      mpu_tx_shift_buffer_r <= 8'h00;
      shift_full_r <= 1'b0;
      timer_r <= DELAY_ZERO;
      timed_out_r <= 1'b1;
      read_seen_r <= 1'b1;
      host_empty_r <= 1'b1;
    end
    else
    begin
      host_tx_holding_reg_r <= host_tx_holding_reg_nxt;
      hold_full_r <= hold_full_nxt;
      hold_empty_r <= hold_empty_nxt;
      mpu_tx_shift_buffer_r <= mpu_tx_shift_buffer_nxt;
      shift_full_r <= shift_full_nxt;
      timer_r <= timer_nxt;
      timed_out_r <= timed_out_nxt;
      read_seen_r <= read_seen_nxt;
      host_empty_r <= host_empty_nxt;
    end
  end

  // ------------------------------------------------------------
  // registers, interrupts and bus answer
  // ------------------------------------------------------------
  // status set wins over a clear in the same cycle
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    delay_nxt = delay_r;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = acc;
    if (acc && apb_req.pwrite && !wr_mapped(apb_req.paddr))
      pslverr_nxt = 1'b1;
    if (wr_done)
    begin
      unique case (apb_req.paddr)
        ADDR_CTRL: ctrl_nxt = apb_req.pwdata[1:0];
        ADDR_IRQ_CLR: irq_stat_nxt = irq_stat_r & ~apb_req.pwdata[IRQ_W-1:0];
        ADDR_IRQ_EN: irq_en_nxt = apb_req.pwdata[IRQ_W-1:0];
        ADDR_DELAY: delay_nxt = apb_req.pwdata[DELAY_W-1:0];
        default: ;
      endcase
    end
    if (rd_acc)
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (apb_req.paddr)
        ADDR_CTRL: prdata_nxt[1:0] = ctrl_r;
        ADDR_HOLD: prdata_nxt[7:0] = host_tx_holding_reg_r;
        ADDR_SHIFT: prdata_nxt[7:0] = mpu_tx_shift_buffer_r;
        ADDR_STAT:
        begin
          prdata_nxt[STAT_HOLD_EMPTY] = !hold_full_r;
          prdata_nxt[STAT_TX_EMPTY] = !shift_full_r;
          prdata_nxt[STAT_SHIFT_FULL] = shift_full_r;
        end
        ADDR_IRQ_STAT: prdata_nxt[IRQ_W-1:0] = irq_stat_r;
        ADDR_IRQ_EN: prdata_nxt[IRQ_W-1:0] = irq_en_r;
        ADDR_DELAY: prdata_nxt[DELAY_W-1:0] = delay_r;
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (shift_full_nxt && !shift_full_r)
      irq_stat_nxt[IRQ_SHIFT_FULL] = 1'b1;
    if (host_empty_nxt && !host_empty_r)
      irq_stat_nxt[IRQ_HOST_EMPTY] = 1'b1;
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
    req_nxt = shift_full_nxt;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_r <= CTRL_RESET;
      delay_r <= DELAY_RESET;
      irq_en_r <= '0;
      irq_stat_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      req_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      delay_r <= delay_nxt;
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      req_r <= req_nxt;
    end
  end

  // outputs straight from flops; mpu interrupt and dma request both carry req_r
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign holding_empty_flag = hold_empty_r;
  assign transmitter_empty_flag = host_empty_r;
  assign mpu_interrupt_request = req_r;
  assign dma_request = req_r;
  assign irq = irq_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_hold_flag;
    @(posedge clock) disable iff (reset)
    holding_empty_flag == !hold_full_r;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("hold flag");

  property p_req_follows;
    @(posedge clock) disable iff (reset)
    req_r == shift_full_r;
  endproperty
  a_req_follows: assert property (p_req_follows) else $error("req");

  property p_move_wait;
    @(posedge clock) disable iff (reset)
    (delay_mode && hold_full_r && !timed_out_r && !fifo_reset)
      |=> hold_full_r && !$rose(shift_full_r);
  endproperty
  a_move_wait: assert property (p_move_wait) else $error("early move");

  sequence s_fill;
    move && !fifo_reset;
  endsequence

  property p_reload;
    @(posedge clock) disable iff (reset)
    s_fill |=> timer_r == $past(delay_r) && !timed_out_r;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_fill_req;
    @(posedge clock) disable iff (reset)
    s_fill |=> shift_full_r && req_r;
  endproperty
  a_fill_req: assert property (p_fill_req) else $error("fill");

  property p_read_empties;
    @(posedge clock) disable iff (reset)
    (mpu_read && shift_full_r && !move) |=> !shift_full_r;
  endproperty
  a_read_empties: assert property (p_read_empties) else $error("read");

  property p_host_set;
    @(posedge clock) disable iff (reset)
    ($rose(host_empty_r) && $past(delay_mode) && !$past(fifo_reset))
      |-> $past(timer_r) == DELAY_ZERO && !$past(hold_full_r);
  endproperty
  a_host_set: assert property (p_host_set) else $error("host set");

  property p_host_clear;
    @(posedge clock) disable iff (reset)
    (host_wr && !fifo_reset) |=> !host_empty_r;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("clear");

  property p_timeout_rst;
    @(posedge clock) disable iff (reset)
    fifo_reset |=> timed_out_r;
  endproperty
  a_timeout_rst: assert property (p_timeout_rst) else $error("tmo");

endmodule

// *** design/tx_dbuf_pkg.sv ***
// shared constants and types for the host transmit double buffer
package tx_dbuf_pkg;

  // ------------------------------------------------------------
  // apb register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOLD = 8'h04;
  localparam logic [7:0] ADDR_SHIFT = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam logic [7:0] ADDR_DELAY = 8'h1c;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_CHAR_DELAY = 1;
  localparam int CTRL_FIFO_RESET = 2;
  localparam int STAT_HOLD_EMPTY = 5;
  localparam int STAT_TX_EMPTY = 6;
  localparam int STAT_SHIFT_FULL = 7;
  localparam int IRQ_SHIFT_FULL = 0;
  localparam int IRQ_HOST_EMPTY = 1;
  localparam int IRQ_W = 2;

  // ------------------------------------------------------------
  // reset values and widths
  // ------------------------------------------------------------
  localparam int DELAY_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0400;
  localparam logic [DELAY_W-1:0] DELAY_ZERO = 16'h0000;
  localparam logic [DELAY_W-1:0] DELAY_ONE = 16'h0001;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // apb request carried as one group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// *** verif/host_tx_writer.sv ***
// host side writer model feeding the holding register
module host_tx_writer
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // status seen by the host
  input wire logic holding_empty_flag,
  // host write port
  output logic host_wr,
  output logic [7:0] host_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle values at time zero
  initial
  begin
    host_wr = 1'b0;
    host_wdata = 8'h00;
  end

  // one byte, only once the holding register reports empty
  task send(input logic [7:0] b);
    @(posedge clock);
    while (reset !== 1'b0 || holding_empty_flag !== 1'b1)
      @(posedge clock);
    host_wr <= 1'b1;
    host_wdata <= b;
    @(posedge clock);
    host_wr <= 1'b0;
    // released data flips so a stale byte cannot pass for a fresh one
    host_wdata <= ~b;
  endtask
endmodule

// *** verif/test_host_uart_tx_double_buffer.sv ***
// self-checking bench for the host transmit double buffer
module test_host_uart_tx_double_buffer
  import tx_dbuf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic e; logic [31:0] d; logic [31:0] m;} note_t;
  logic clock, reset, pready, pslverr, host_wr, holding_empty_flag;
  logic transmitter_empty_flag, mpu_interrupt_request, dma_request, irq;
  logic [31:0] prdata;
  logic [7:0] host_wdata, b1, b2;
  apb_req_t apb_req;
  note_t notes[$];
  note_t nt;
  int n_errors, cmp_count, seed, i;

  // ------------------------------------------------------------
  // design and host model
  // ------------------------------------------------------------
  host_uart_tx_double_buffer DUT (.clock(clock), .reset(reset),
    .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_wr(host_wr), .host_wdata(host_wdata),
    .holding_empty_flag(holding_empty_flag),
    .transmitter_empty_flag(transmitter_empty_flag),
    .mpu_interrupt_request(mpu_interrupt_request),
    .dma_request(dma_request), .irq(irq));
  host_tx_writer host_side (.clock(clock), .reset(reset),
    .holding_empty_flag(holding_empty_flag), .host_wr(host_wr),
    .host_wdata(host_wdata));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // apb transfer; the expectation is noted before the request goes out
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, m,
    input logic e);
    notes.push_back('{e, d & m, m});
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    apb_req <= '{1'b0, 1'b0, 1'b0, 8'h00, 32'h0};
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 32'hffffffff, 1'b0);
  endtask

  // sample a little after the edge so registered outputs have landed
  task settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task close_out;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // compare each bus answer with the oldest noted expectation
  always @(posedge clock)
    if (pready === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk("prdata", prdata & nt.m, nt.d);
      chk("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
    end

  // clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    close_out();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 32404;
    reset = 1'b1;
    apb_req = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    settle(1);
    chk("hold_empty", holding_empty_flag, 32'h1);
    chk("tx_empty", transmitter_empty_flag, 32'h1);
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_DELAY, 32'(DELAY_RESET));
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    apb(1'b1, ADDR_HOLD, 32'h0, 32'h0, 1'b1);
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_IRQ_EN, 32'h1);
    // plain double buffering, no pacing
    b1 = 8'($random(seed));
    host_side.send(b1);
    settle(4);
    chk("tx_empty", transmitter_empty_flag, 32'h0);
    chk("mpu_req", mpu_interrupt_request, 32'h1);
    chk("dma_req", dma_request, 32'h1);
    chk("irq", irq, 32'h1);
    rd(ADDR_STAT, 32'h1 << STAT_HOLD_EMPTY | 32'h1 << STAT_SHIFT_FULL);
    wr(ADDR_IRQ_EN, 32'h0);
    settle(2);
    chk("irq", irq, 32'h0);
    wr(ADDR_IRQ_EN, 32'h1);
    rd(ADDR_SHIFT, {24'h0, b1});
    rd(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_IRQ_CLR, 32'h3);
    settle(2);
    chk("irq", irq, 32'h0);
    chk("mpu_req", mpu_interrupt_request, 32'h0);
    chk("tx_empty", transmitter_empty_flag, 32'h1);
    rd(ADDR_STAT, 32'h1 << STAT_HOLD_EMPTY | 32'h1 << STAT_TX_EMPTY);
    // disabled: the byte waits in holding until enable returns
    wr(ADDR_CTRL, 32'h0);
    b1 = 8'($random(seed));
    host_side.send(b1);
    settle(3);
    chk("mpu_req", mpu_interrupt_request, 32'h0);
    chk("hold_empty", holding_empty_flag, 32'h0);
    chk("tx_empty", transmitter_empty_flag, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    settle(2);
    chk("mpu_req", mpu_interrupt_request, 32'h1);
    rd(ADDR_SHIFT, {24'h0, b1});
    // paced mode: fifo reset leaves the timer timed out
    wr(ADDR_DELAY, 32'h28);
    wr(ADDR_CTRL, 32'h7);
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    host_side.send(b1);
    host_side.send(b2);
    settle(3);
    chk("hold_empty", holding_empty_flag, 32'h0);
    rd(ADDR_SHIFT, {24'h0, b1});
    settle(2);
    chk("hold_empty", holding_empty_flag, 32'h0);
    for (i = 0; i < 80 && holding_empty_flag !== 1'b1; i++)
      settle(1);
    chk("hold_empty", holding_empty_flag, 32'h1);
    rd(ADDR_SHIFT, {24'h0, b2});
    settle(1);
    chk("tx_empty", transmitter_empty_flag, 32'h0);
    for (i = 0; i < 80 && transmitter_empty_flag !== 1'b1; i++)
      settle(1);
    chk("tx_empty", transmitter_empty_flag, 32'h1);
    close_out();
  end
endmodule
